// ---- src/lsau_core.sv ----
// Address generation and sequencing for loads, stores, multiples and stack
`timescale 1ns/1ps
`include "lsau_regs.svh"

// Function
// - Relative address adds immediate to program counter into low register
// - No instruction of this group touches the condition flags
// - Unsigned byte and halfword loads are zero extended to 32 bits
// - Stores write full word, low byte or low halfword
// - Immediate forms address base or stack pointer plus immediate
// - Word immediates: stack base 0-1020, low base 0-124, step four
// - Halfword immediates even 0-62; byte immediates 0-31
// - Every access address is a multiple of its size
// - Misaligned access raises the hard fault exception
// - Register-offset loads offer word, zero and sign extended forms
// - Register-offset address is base plus offset register
// - Literal load reads aligned word within 1020 of program counter
// - Program counter used is current instruction address plus four, rounded down to a word boundary
// - Multiples access consecutive words from base upward by four
// - Multiples go in ascending register order
// - Writeback sets base to original base plus four times count
// - Writeback mandatory unless multiple load lists its base
// - Multiples use low registers only and a word aligned base
// - Multiple store of base valid only if base is lowest listed; not checked, no fault is raised
// - Empty register list is illegal
// - Push stores highest at stack pointer minus four, descending
// - Pop reads upward; stack pointer ends above highest loaded
// - Pop into program counter branches after completion, bit 0 to state
// - Stack lists low registers plus link register or program counter
module lsau_core import lsau_pkg::*; (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic req_valid,
    input lsau_req_s req,
    output logic req_ready,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [3:0] mem_be,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic [3:0] rf_raddr,
    input wire logic [31:0] rf_rdata,
    output logic rf_we,
    output logic [3:0] rf_waddr,
    output logic [31:0] rf_wdata,
    output logic flags_we,
    output logic br_valid,
    output logic [31:0] br_target,
    output logic tbit,
    output logic hard_fault,
    output logic done
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    lsau_state_e st_q, st_d;
    lsau_op_e op_q, op_d;
    lsau_size_e size_q, size_d;
    logic sgn_q, sgn_d, multi_q, multi_d, wb_q, wb_d;
    logic [31:0] addr_q, addr_d, wbv_q, wbv_d, sdata_q, sdata_d;
    logic [31:0] brt_q, brt_d;
    logic [8:0] list_q, list_d;
    logic [3:0] idx_q, idx_d, wbreg_q, wbreg_d;
    logic pcload_q, pcload_d;
    logic ready_q, ready_d, mreq_q, mreq_d, mwe_q, mwe_d;
    logic [31:0] maddr_q, maddr_d, mwdata_q, mwdata_d;
    logic [3:0] mbe_q, mbe_d, raddr_q, raddr_d, waddr_q, waddr_d;
    logic rfwe_q, rfwe_d, flg_q, flg_d, brv_q, brv_d, tbit_q, tbit_d;
    logic [31:0] wdata_q, wdata_d, brtgt_q, brtgt_d;
    logic fault_q, fault_d, done_q, done_d;
    logic fire, legal, mis, bad, eff_word, list_ok, xbit;
    logic [3:0] cnt, low;
    logic [31:0] span, pc_word, ad, wbv, rdb;
    logic [3:0] l_be;
    logic [31:0] l_wlane, l_ldval, l_sdata;
    logic [8:0] list_nx;

    assign fire = req_valid && ready_q;

    // ------------------------------------------------------------
    // Request check and address forming
    // ------------------------------------------------------------
    always_comb begin
        cnt = 4'h0;
        for (int i = 0; i < 9; i++) begin
            cnt = cnt + {3'h0, req.reg_list[i]};
        end
        span = {26'h0, cnt, 2'b00};
        pc_word = (req.program_counter + `LSAU_PC_AHEAD)
                  & `LSAU_WORD_MASK;
        rdb = req.base_val;
        list_ok = (req.reg_list != 9'h000);
        xbit = req.reg_list[`LSAU_XBIT];
        legal = 1'b1;
        ad = rdb + req.offset_val;
        wbv = rdb + span;
        eff_word = (req.size == SZ_WORD);
        case (req.op)
            OP_ADR, OP_LD_LIT: begin
                ad = pc_word + req.offset_val;
                legal = (req.offset_val <= `LSAU_REL_MAX)
                        && (req.offset_val[1:0] == 2'h0);
                eff_word = 1'b1;
            end
            OP_LD_IMM, OP_ST_IMM: begin
                case (req.size)
                    SZ_WORD: legal = (req.offset_val[1:0] == 2'h0)
                        && (req.offset_val <= (req.base_is_stack ?
                        `LSAU_STK_WORD_MAX : `LSAU_LO_WORD_MAX));
                    SZ_HALF: legal = !req.base_is_stack
                        && (req.offset_val <= `LSAU_HALF_MAX)
                        && !req.offset_val[0];
                    default: legal = !req.base_is_stack
                        && (req.offset_val <= `LSAU_BYTE_MAX);
                endcase
            end
            OP_LD_REG, OP_ST_REG: legal = 1'b1;
            OP_MULTI_LOAD: begin
                ad = rdb;
                eff_word = 1'b1;
                legal = list_ok && !xbit && (req.writeback
                        != req.reg_list[req.base_register]);
            end
            OP_MULTI_STORE: begin
                ad = rdb;
                eff_word = 1'b1;
                legal = list_ok && !xbit && req.writeback;
            end
            OP_PUSH: begin
                ad = rdb - span;
                wbv = rdb - span;
                eff_word = 1'b1;
                legal = list_ok;
            end
            OP_POP: begin
                ad = rdb;
                eff_word = 1'b1;
                legal = list_ok;
            end
            default: legal = 1'b0;
        endcase
        if (eff_word) begin
            mis = (ad[1:0] != 2'h0);
        end else if (req.size == SZ_HALF) begin
            mis = ad[0];
        end else begin
            mis = 1'b0;
        end
        bad = !legal || (mis && req.op != OP_ADR);
    end

    // ------------------------------------------------------------
    // Lane steering
    // ------------------------------------------------------------
    // Multiple stores take data from the register file read port
    assign l_sdata = multi_q ? rf_rdata : sdata_q;

    lsau_lane u_lane (
        .size(size_q),
        .sgn(sgn_q),
        .lsb(addr_q[1:0]),
        .sdata(l_sdata),
        .rdata(mem_rdata),
        .be(l_be),
        .wlane(l_wlane),
        .ldval(l_ldval)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q; op_d = op_q; size_d = size_q; sgn_d = sgn_q;
        multi_d = multi_q; wb_d = wb_q; addr_d = addr_q;
        wbv_d = wbv_q; sdata_d = sdata_q; brt_d = brt_q;
        list_d = list_q; idx_d = idx_q; wbreg_d = wbreg_q;
        pcload_d = pcload_q; ready_d = ready_q; mreq_d = mreq_q;
        mwe_d = mwe_q; maddr_d = maddr_q; mwdata_d = mwdata_q;
        mbe_d = mbe_q; raddr_d = raddr_q; waddr_d = waddr_q;
        wdata_d = wdata_q; brtgt_d = brtgt_q; tbit_d = tbit_q;
        rfwe_d = 1'b0; brv_d = 1'b0; fault_d = 1'b0; done_d = 1'b0;
        flg_d = 1'b0;
        low = 4'h0;
        for (int i = 8; i >= 0; i--) begin
            if (list_q[i]) begin
                low = 4'(i);
            end
        end
        list_nx = list_q & ~(9'h001 << low);
        case (st_q)
            ST_IDLE: begin
                if (fire) begin
                    op_d = req.op;
                    size_d = req.size;
                    sgn_d = req.sgn && (req.op == OP_LD_REG);
                    addr_d = ad;
                    sdata_d = req.store_data;
                    list_d = req.reg_list;
                    wbv_d = wbv;
                    idx_d = {1'b0, req.transfer_register};
                    pcload_d = 1'b0;
                    if (bad) begin
                        fault_d = 1'b1;
                    end else if (req.op == OP_ADR) begin
                        rfwe_d = 1'b1;
                        waddr_d = {1'b0, req.transfer_register};
                        wdata_d = ad;
                        done_d = 1'b1;
                    end else if (req.op >= OP_MULTI_LOAD) begin
                        multi_d = 1'b1;
                        size_d = SZ_WORD;
                        sgn_d = 1'b0;
                        wb_d = req.writeback || req.op >= OP_PUSH;
                        wbreg_d = (req.op >= OP_PUSH) ? `LSAU_STACK_IDX
                                  : {1'b0, req.base_register};
                        ready_d = 1'b0;
                        st_d = ST_SEL;
                    end else begin
                        multi_d = 1'b0;
                        wb_d = 1'b0;
                        if (req.op == OP_LD_LIT) begin
                            size_d = SZ_WORD;
                            sgn_d = 1'b0;
                        end
                        ready_d = 1'b0;
                        st_d = ST_ISSUE;
                    end
                end
            end
            ST_SEL: begin
                // Lowest set bit first keeps addresses ascending
                if (low == 4'h8) begin
                    idx_d = (op_q == OP_PUSH) ? `LSAU_LINK_IDX
                            : `LSAU_PROG_IDX;
                end else begin
                    idx_d = low;
                end
                raddr_d = idx_d;
                st_d = ST_ISSUE;
            end
            ST_ISSUE: begin
                mreq_d = 1'b1;
                mwe_d = (op_q == OP_ST_IMM) || (op_q == OP_ST_REG)
                        || (op_q == OP_MULTI_STORE) || (op_q == OP_PUSH);
                maddr_d = addr_q;
                mbe_d = l_be;
                mwdata_d = l_wlane;
                st_d = ST_MEM;
            end
            ST_MEM: begin
                if (mem_ack) begin
                    mreq_d = 1'b0;
                    mwe_d = 1'b0;
                    if (!mwe_q) begin
                        if (multi_q && idx_q == `LSAU_PROG_IDX) begin
                            brt_d = mem_rdata;
                            pcload_d = 1'b1;
                        end else begin
                            rfwe_d = 1'b1;
                            waddr_d = idx_q;
                            wdata_d = l_ldval;
                        end
                    end
                    if (!multi_q) begin
                        done_d = 1'b1;
                        ready_d = 1'b1;
                        st_d = ST_IDLE;
                    end else begin
                        list_d = list_nx;
                        addr_d = addr_q + 32'h0000_0004;
                        st_d = (list_nx == 9'h000) ? ST_FIN : ST_SEL;
                    end
                end
            end
            ST_FIN: begin
                // Base update only after the last bus word
                if (wb_q) begin
                    rfwe_d = 1'b1;
                    waddr_d = wbreg_q;
                    wdata_d = wbv_q;
                end
                if (pcload_q) begin
                    brv_d = 1'b1;
                    brtgt_d = {brt_q[31:1], 1'b0};
                    tbit_d = brt_q[0];
                end
                done_d = 1'b1;
                ready_d = 1'b1;
                st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_IDLE; op_q <= OP_ADR; size_q <= SZ_WORD;
            sgn_q <= 1'b0; multi_q <= 1'b0; wb_q <= 1'b0;
            addr_q <= 32'h0; wbv_q <= 32'h0; sdata_q <= 32'h0;
            brt_q <= 32'h0; list_q <= 9'h000; idx_q <= 4'h0;
            wbreg_q <= 4'h0; pcload_q <= 1'b0; ready_q <= 1'b1;
            mreq_q <= 1'b0; mwe_q <= 1'b0; maddr_q <= 32'h0;
            mwdata_q <= 32'h0; mbe_q <= 4'h0; raddr_q <= 4'h0;
            waddr_q <= 4'h0; wdata_q <= 32'h0; brtgt_q <= 32'h0;
            tbit_q <= 1'b0; rfwe_q <= 1'b0; brv_q <= 1'b0;
            fault_q <= 1'b0; done_q <= 1'b0; flg_q <= 1'b0;
        end else begin
            st_q <= st_d; op_q <= op_d; size_q <= size_d;
            sgn_q <= sgn_d; multi_q <= multi_d; wb_q <= wb_d;
            addr_q <= addr_d; wbv_q <= wbv_d; sdata_q <= sdata_d;
            brt_q <= brt_d; list_q <= list_d; idx_q <= idx_d;
            wbreg_q <= wbreg_d; pcload_q <= pcload_d; ready_q <= ready_d;
            mreq_q <= mreq_d; mwe_q <= mwe_d; maddr_q <= maddr_d;
            mwdata_q <= mwdata_d; mbe_q <= mbe_d; raddr_q <= raddr_d;
            waddr_q <= waddr_d; wdata_q <= wdata_d; brtgt_q <= brtgt_d;
            tbit_q <= tbit_d; rfwe_q <= rfwe_d; brv_q <= brv_d;
            fault_q <= fault_d; done_q <= done_d; flg_q <= flg_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign req_ready = ready_q;
    assign mem_req = mreq_q;
    assign mem_we = mwe_q;
    assign mem_addr = maddr_q;
    assign mem_be = mbe_q;
    assign mem_wdata = mwdata_q;
    assign rf_raddr = raddr_q;
    assign rf_we = rfwe_q;
    assign rf_waddr = waddr_q;
    assign rf_wdata = wdata_q;
    assign flags_we = flg_q;
    assign br_valid = brv_q;
    assign br_target = brtgt_q;
    assign tbit = tbit_q;
    assign hard_fault = fault_q;
    assign done = done_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_bad_take;
        fire && bad;
    endsequence
    sequence s_adr_take;
        fire && !bad && req.op == OP_ADR;
    endsequence

    property p_flags_quiet;
        !flags_we;
    endproperty
    a_flags_quiet: assert property (p_flags_quiet)
        else $error("flag write from memory unit");

    property p_fault_pulse;
        s_bad_take |=> hard_fault && !mem_req ##1 !hard_fault;
    endproperty
    a_fault_pulse: assert property (p_fault_pulse)
        else $error("illegal request without single fault pulse");

    property p_empty_list;
        fire && req.op >= OP_MULTI_LOAD && req.reg_list == 9'h000
            |=> hard_fault;
    endproperty
    a_empty_list: assert property (p_empty_list)
        else $error("empty list not faulted");

    property p_adr_sum;
        s_adr_take |=> rf_we && rf_wdata == ((($past(req.program_counter)
            + 32'h4) & 32'hffff_fffc) + $past(req.offset_val));
    endproperty
    a_adr_sum: assert property (p_adr_sum)
        else $error("relative address wrong");

    property p_word_aligned;
        mem_req && mem_be == 4'hf |-> mem_addr[1:0] == 2'h0;
    endproperty
    a_word_aligned: assert property (p_word_aligned)
        else $error("misaligned word on bus");

    property p_multi_step;
        st_q == ST_MEM && mem_ack && multi_q && list_nx != 9'h000
            |=> addr_q == $past(addr_q) + 32'h4 ##2 mem_addr == addr_q;
    endproperty
    a_multi_step: assert property (p_multi_step)
        else $error("multiple transfer step not four");

    property p_zero_ext;
        st_q == ST_MEM && mem_ack && !mwe_q && !sgn_q
            && size_q == SZ_BYTE |=> rf_we && rf_wdata[31:8] == 24'h0;
    endproperty
    a_zero_ext: assert property (p_zero_ext)
        else $error("byte load not zero extended");

    property p_sign_ext;
        st_q == ST_MEM && mem_ack && !mwe_q && sgn_q
            && size_q == SZ_HALF
            |=> rf_wdata[31:16] == {16{rf_wdata[15]}};
    endproperty
    a_sign_ext: assert property (p_sign_ext)
        else $error("halfword load not sign extended");

    property p_byte_lanes;
        mem_req && mem_we && mem_be == 4'h1
            |-> mem_wdata[31:24] == mem_wdata[7:0];
    endproperty
    a_byte_lanes: assert property (p_byte_lanes)
        else $error("byte store lanes differ");

    property p_branch_end;
        br_valid |-> done && rf_we && rf_waddr == 4'hd && !br_target[0];
    endproperty
    a_branch_end: assert property (p_branch_end)
        else $error("branch not with final stack update");
endmodule

// ---- pkg/lsau_regs.svh ----
// Limits, offsets and register indices of the load/store address unit
`ifndef LSAU_REGS_SVH
`define LSAU_REGS_SVH
`define LSAU_PC_AHEAD 32'h0000_0004
`define LSAU_WORD_MASK 32'hffff_fffc
`define LSAU_STK_WORD_MAX 32'h0000_03fc
`define LSAU_LO_WORD_MAX 32'h0000_007c
`define LSAU_HALF_MAX 32'h0000_003e
`define LSAU_BYTE_MAX 32'h0000_001f
`define LSAU_REL_MAX 32'h0000_03fc
`define LSAU_XBIT 8
`define LSAU_STACK_IDX 4'hd
`define LSAU_LINK_IDX 4'he
`define LSAU_PROG_IDX 4'hf
`endif

// ---- pkg/lsau_pkg.sv ----
// Types shared by the load/store address unit
package lsau_pkg;
    typedef enum logic [3:0] {
        OP_ADR = 4'b0000,
        OP_LD_IMM = 4'b0001,
        OP_LD_REG = 4'b0010,
        OP_LD_LIT = 4'b0011,
        OP_ST_IMM = 4'b0100,
        OP_ST_REG = 4'b0101,
        OP_MULTI_LOAD = 4'b0110,
        OP_MULTI_STORE = 4'b0111,
        OP_PUSH = 4'b1000,
        OP_POP = 4'b1001
    } lsau_op_e;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } lsau_size_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEL = 3'b001,
        ST_ISSUE = 3'b010,
        ST_MEM = 3'b011,
        ST_FIN = 3'b100
    } lsau_state_e;

    typedef struct packed {
        lsau_op_e op;
        lsau_size_e size;
        logic sgn;
        logic base_is_stack;
        logic writeback;
        logic [2:0] transfer_register;
        logic [2:0] base_register;
        logic [31:0] base_val;
        logic [31:0] offset_val;
        logic [31:0] program_counter;
        logic [31:0] store_data;
        logic [8:0] reg_list;
    } lsau_req_s;
endpackage

// ---- src/lsau_lane.sv ----
// Byte lane steering for stores and extension for loads
`timescale 1ns/1ps
module lsau_lane import lsau_pkg::*; (
    input lsau_size_e size,
    input wire logic sgn,
    input wire logic [1:0] lsb,
    input wire logic [31:0] sdata,
    input wire logic [31:0] rdata,
    output logic [3:0] be,
    output logic [31:0] wlane,
    output logic [31:0] ldval
);
    logic [7:0] b;
    logic [15:0] h;

    always_comb begin
        b = 8'h00;
        h = 16'h0000;
        case (size)
            SZ_BYTE: begin
                be = 4'h1 << lsb;
                wlane = {4{sdata[7:0]}};
                case (lsb)
                    2'h0: b = rdata[7:0];
                    2'h1: b = rdata[15:8];
                    2'h2: b = rdata[23:16];
                    default: b = rdata[31:24];
                endcase
                ldval = sgn ? {{24{b[7]}}, b} : {24'h000000, b};
            end
            SZ_HALF: begin
                be = lsb[1] ? 4'hc : 4'h3;
                wlane = {2{sdata[15:0]}};
                h = lsb[1] ? rdata[31:16] : rdata[15:0];
                ldval = sgn ? {{16{h[15]}}, h} : {16'h0000, h};
            end
            default: begin
                be = 4'hf;
                wlane = sdata;
                ldval = rdata;
            end
        endcase
    end
endmodule

// ---- tb/lsau_mem_model.sv ----
// Memory partner answering single-word bus transfers
`timescale 1ns/1ps
module lsau_mem_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [3:0] mem_be,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] m [16];
    int w;
    initial begin
        for (int i = 0; i < 16; i++) begin
            m[i] = {i[3:0], 4'h8, 16'h7ef3, i[3:0], 4'h1};
        end
    end
    // Random wait; read data is scrambled once ack drops
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_ack <= 1'b0;
            w <= 0;
        end else if (mem_ack || !mem_req) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end else if (w == 0) begin
            mem_ack <= 1'b1;
            mem_rdata <= m[mem_addr[5:2]];
            w <= $urandom_range(0, 3);
            for (int k = 0; k < 4; k++) begin
                if (mem_we && mem_be[k]) begin
                    m[mem_addr[5:2]][8*k+:8] <= mem_wdata[8*k+:8];
                end
            end
        end else begin
            w <= w - 1;
        end
    end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the load/store address unit
`timescale 1ns/1ps
module tb;
    import lsau_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0;
    lsau_req_s req = '0;
    logic req_ready, mem_req, mem_we, mem_ack, rf_we, flags_we, br_valid;
    logic tbit, hard_fault, done;
    logic [31:0] mem_addr, mem_wdata, mem_rdata, rf_rdata, rf_wdata;
    logic [31:0] br_target;
    logic [3:0] mem_be, rf_raddr, rf_waddr;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [71:0] q [$];
    lsau_size_e sz [5] = '{SZ_WORD, SZ_BYTE, SZ_HALF, SZ_BYTE, SZ_HALF};
    always #25 clk_sys = ~clk_sys;
    assign rf_rdata = 32'hc0de_0001 + {20'h0, rf_raddr, 8'h0};
    lsau_core lsau_core_inst (.clk_sys, .rstn, .req_valid, .req, .req_ready,
        .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_ack,
        .mem_rdata, .rf_raddr, .rf_rdata, .rf_we, .rf_waddr, .rf_wdata,
        .flags_we, .br_valid, .br_target, .tbit, .hard_fault, .done);
    lsau_mem_model lsau_mem_model_inst (.clk_sys, .rstn, .mem_req, .mem_we,
        .mem_addr, .mem_be, .mem_wdata, .mem_ack, .mem_rdata);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rv(logic [3:0] a);
        return 32'hc0de_0001 + {20'h0, a, 8'h0};
    endfunction
    function automatic logic [31:0] mv(logic [3:0] i);
        return {i, 4'h8, 16'h7ef3, i, 4'h1};
    endfunction
    function automatic logic [31:0] ext(logic [31:0] v, logic [1:0] l,
        lsau_size_e s, logic g);
        logic [31:0] x;
        x = v >> (8 * l);
        if (s == SZ_BYTE) return {{24{g & x[7]}}, x[7:0]};
        if (s == SZ_HALF) return {{16{g & x[15]}}, x[15:0]};
        return v;
    endfunction
    function automatic lsau_req_s mk(lsau_op_e o, lsau_size_e s, logic g,
        stk, wb, logic [2:0] t, b, logic [31:0] bv, ov, pc, sd,
        logic [8:0] l);
        return '{o, s, g, stk, wb, t, b, bv, ov, pc, sd, l};
    endfunction
    task automatic ex(logic [3:0] k, s, logic [31:0] a, d);
        q.push_back({k, s, a, d});
    endtask
    task automatic chk(logic [71:0] g);
        logic [71:0] e;
        n_tests++;
        e = (q.size() > 0) ? q.pop_front() : '1;
        if (e !== g) begin
            miscompares++;
            $display("ERROR event expected %h seen %h", e, g);
        end
    endtask
    task automatic run(lsau_req_s r);
        int n;
        @(negedge clk_sys);
        req = r;
        req_valid = 1'b1;
        n = 0;
        do @(posedge clk_sys); while (req_ready !== 1'b1 && ++n < 50);
        @(negedge clk_sys);
        req_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && hard_fault !== 1'b1 && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 60) miscompares++;
    endtask
    task automatic flt(lsau_req_s r);
        ex(4, 0, 0, 0);
        run(r);
    endtask
    task automatic ld(lsau_req_s r, logic [3:0] be, logic [31:0] a, d);
        ex(1, be, a, 0);
        ex(3, {1'b0, r.transfer_register}, 0, d);
        run(r);
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Observer and watchdog
    // ------------------------------------------------------------
    always @(negedge clk_sys) begin
        cyc++;
        if (cyc == 8000) begin
            miscompares++;
            finish_test();
        end
        if (rstn && mem_req && mem_ack)
            chk({mem_we ? 4'h2 : 4'h1, mem_be, mem_addr, mem_we ? mem_wdata : 32'h0});
        if (rstn && rf_we !== 1'b0) chk({4'h3, rf_waddr, 32'h0, rf_wdata});
        if (rstn && hard_fault !== 1'b0) chk({4'h4, 68'h0});
        if (rstn && br_valid !== 1'b0) chk({4'h5, 3'h0, tbit, 32'h0, br_target});
        if (flags_we !== 1'b0) begin
            miscompares++;
            $display("ERROR flags_we expected 0 seen %b", flags_we);
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        logic [1:0] ln;
        logic [31:0] a, sd;
        int j;
        void'($urandom(51));
        repeat (5) @(negedge clk_sys);
        rstn = 1'b1;
        ex(3, 3, 0, 32'h500);
        run(mk(OP_ADR, SZ_WORD, 0, 0, 0, 3, 0, 0, 32'h3fc, 32'h102, 0, 0));
        flt(mk(OP_ADR, SZ_WORD, 0, 0, 0, 3, 0, 0, 32'h400, 32'h102, 0, 0));
        ld(mk(OP_LD_LIT, SZ_WORD, 0, 0, 0, 5, 0, 0, 8, 2, 0, 0), 15, 12, mv(3));
        ld(mk(OP_LD_IMM, SZ_WORD, 0, 1, 0, 2, 0, 0, 32'h3fc, 0, 0, 0), 15,
           32'h3fc, mv(15));
        for (int k = 0; k < 14; k++) begin
            j = (k < 8) ? k % 5 : k % 3;
            ln = (sz[j] == SZ_BYTE) ? $urandom_range(0, 3) :
                 (sz[j] == SZ_HALF) ? 2 * $urandom_range(0, 1) : 0;
            a = (k < 8 ? 0 : 32) + 4 * $urandom_range(0, 3) + ln;
            sd = $urandom;
            if (k < 8) begin
                ld(mk(k < 5 ? OP_LD_REG : OP_LD_IMM, sz[j], k > 2,
                   0, 0, k, 1, a & 32'h1c, a & 32'h3, 0, 0, 0),
                   sz[j] == SZ_WORD ? 4'hf : (sz[j] == SZ_HALF ? 4'h3 : 4'h1) << ln,
                   a, ext(mv(a[5:2]), ln, sz[j], k == 3 || k == 4));
            end else begin
                ex(2, sz[j] == SZ_WORD ? 4'hf : (sz[j] == SZ_HALF ? 4'h3 : 4'h1) << ln,
                   a, sz[j] == SZ_WORD ? sd : (sz[j] == SZ_HALF ?
                   {2{sd[15:0]}} : {4{sd[7:0]}}));
                run(mk(k < 11 ? OP_ST_IMM : OP_ST_REG, sz[j], 0, 0, 0, 1, 2,
                    32, a - 32, 0, sd, 0));
            end
        end
        flt(mk(OP_LD_IMM, SZ_WORD, 0, 1, 0, 1, 0, 0, 32'h400, 0, 0, 0));
        flt(mk(OP_LD_IMM, SZ_WORD, 0, 0, 0, 1, 2, 0, 32'h80, 0, 0, 0));
        flt(mk(OP_ST_IMM, SZ_HALF, 0, 0, 0, 1, 2, 0, 32'h40, 0, 0, 0));
        flt(mk(OP_ST_IMM, SZ_BYTE, 0, 0, 0, 1, 2, 0, 32'h20, 0, 0, 0));
        flt(mk(OP_LD_REG, SZ_HALF, 1, 0, 0, 1, 2, 32'h11, 0, 0, 0, 0));
        flt(mk(OP_ST_REG, SZ_WORD, 0, 0, 0, 1, 2, 2, 4, 0, 0, 0));
        flt(mk(OP_MULTI_STORE, SZ_WORD, 0, 0, 0, 0, 2, 32, 0, 0, 0, 9'h00a));
        flt(mk(OP_MULTI_LOAD, SZ_WORD, 0, 0, 1, 0, 4, 16, 0, 0, 0, 9'h050));
        flt(mk(OP_PUSH, SZ_WORD, 0, 1, 0, 0, 0, 64, 0, 0, 0, 9'h000));
        flt(mk(OP_MULTI_LOAD, SZ_WORD, 0, 0, 1, 0, 4, 16, 0, 0, 0, 9'h101));
        flt(mk(OP_MULTI_STORE, SZ_WORD, 0, 0, 1, 0, 2, 18, 0, 0, 0, 9'h00a));
        ex(2, 15, 32, rv(1));
        ex(2, 15, 36, rv(3));
        ex(3, 1, 0, 40);
        run(mk(OP_MULTI_STORE, SZ_WORD, 0, 0, 1, 0, 1, 32, 0, 0, 0, 9'h00a));
        ex(1, 15, 16, 0);
        ex(3, 4, 0, mv(4));
        ex(1, 15, 20, 0);
        ex(3, 6, 0, mv(5));
        run(mk(OP_MULTI_LOAD, SZ_WORD, 0, 0, 0, 0, 4, 16, 0, 0, 0, 9'h050));
        for (int k = 0; k < 3; k++) ex(2, 15, 52 + 4 * k, rv(k == 2 ? 14 : 2 * k));
        ex(3, 13, 0, 52);
        run(mk(OP_PUSH, SZ_WORD, 0, 1, 0, 0, 0, 64, 0, 0, 0, 9'h105));
        for (int k = 0; k < 3; k++) begin
            ex(1, 15, 52 + 4 * k, 0);
            if (k < 2) ex(3, k + 1, 0, rv(2 * k));
        end
        ex(3, 13, 0, 64);
        ex(5, 1, 0, rv(14) & ~32'h1);
        run(mk(OP_POP, SZ_WORD, 0, 1, 0, 0, 0, 52, 0, 0, 0, 9'h106));
        repeat (3) @(negedge clk_sys);
        if (q.size() != 0) begin
            miscompares++;
            $display("ERROR pending events expected 0 seen %0d", q.size());
        end
        finish_test();
    end
endmodule
